/* hdl/flt_pkg.sv */
// package: register map, field positions, reset values for fifo level regs
package flt_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses, one 32-bit word per register)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_LEVEL = 8'h00;
  localparam logic [7:0] IDX_FEATURE = 8'h01;
  localparam logic [7:0] IDX_LINE_CTRL = 8'h03;
  localparam logic [9:0] ADDR_LEVEL = 10'h000;
  localparam logic [9:0] ADDR_FEATURE = 10'h004;
  localparam logic [9:0] ADDR_LINE_CTRL = 10'h00c;
  localparam logic [9:0] ADDR_RX_COUNT = 10'h010;
  localparam logic [9:0] ADDR_TX_COUNT = 10'h014;
  localparam logic [9:0] ADDR_TRIG_STAT = 10'h018;
  // ----------------------------------------------------------------
  // values and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] ENHANCED_KEY = 8'hbf;
  localparam logic [7:0] LEVEL_RST = 8'h00;
  localparam logic [7:0] FEATURE_RST = 8'h20;
  localparam logic [7:0] LINE_CTRL_RST = 8'h00;
  localparam logic [6:0] TRIG_RST = 7'h00;
  localparam logic [6:0] TRIG_MAX = 7'h40;
  localparam int SEL_BIT = 7;
  localparam int TABLE_LSB = 4;
  localparam int TABLE_MSB = 5;
  localparam logic [7:0] FEATURE_RW_MASK = 8'h30;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

/* hdl/flt_read_pulse.sv */
// module: one read answer per request, waitrequest cycle generator
`timescale 1ns/1ns
module flt_read_pulse (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic req,
  output logic waitrequest,
  output logic accept
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic busy;
  } flt_rp_state_t;

  flt_rp_state_t st_r;
  flt_rp_state_t st_nxt;

  // one wait cycle, then accept: gives registered read data time to form
  always_comb begin
    st_nxt = st_r;
    if (req && !st_r.busy) begin
      st_nxt.busy = 1'b1;
    end else begin
      st_nxt.busy = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign accept = req && st_r.busy;
  assign waitrequest = req && !st_r.busy;
endmodule

/* hdl/flt_regs.sv */
// module: enhanced fifo trigger and level count registers, avalon slave
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ns
module flt_regs #(
  parameter int CNT_W = 7
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [CNT_W-1:0] rx_count,
  input wire logic [CNT_W-1:0] tx_count,
  output logic [6:0] receive_trigger_level,
  output logic [6:0] transmit_trigger_level,
  output logic [1:0] trigger_table
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] line_control;
    logic [7:0] feature_control;
    logic [6:0] rx_trig;
    logic [6:0] tx_trig;
    logic sel_tx;
    logic [31:0] rdata;
  } flt_state_t;

  flt_state_t st_r;
  flt_state_t st_nxt;
  logic rd_accept;
  logic enhanced;
  logic lane0;
  logic [7:0] level_view;

  // reads take one wait cycle; writes complete in the request cycle
  flt_read_pulse u_rp (
    .ref_clk(ref_clk),
    .rst(rst),
    .req(read),
    .waitrequest(waitrequest),
    .accept(rd_accept)
  );

  assign enhanced = (st_r.line_control == flt_pkg::ENHANCED_KEY);
  assign lane0 = byteenable[0];
  // counts come from logic on the same clock, so no synchroniser
  assign level_view = st_r.sel_tx ? {1'b1, tx_count}
                                  : {1'b0, rx_count};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // read data is registered in the wait cycle, presented on accept
  always_comb begin
    st_nxt = st_r;
    if (write && lane0) begin
      case (address)
        flt_pkg::ADDR_LINE_CTRL: begin
          st_nxt.line_control = writedata[7:0];
        end
        flt_pkg::ADDR_LEVEL: begin
          if (enhanced) begin
            if (writedata[flt_pkg::SEL_BIT]) begin
              st_nxt.tx_trig = writedata[6:0];
            end else begin
              st_nxt.rx_trig = writedata[6:0];
            end
          end
        end
        flt_pkg::ADDR_FEATURE: begin
          if (enhanced) begin
            // reserved 7:6 and other bits keep their value
            st_nxt.feature_control =
              (st_r.feature_control & ~flt_pkg::FEATURE_RW_MASK) |
              (writedata[7:0] & flt_pkg::FEATURE_RW_MASK);
          end
        end
        default: begin
        end
      endcase
    end
    if (read && !rd_accept) begin
      case (address)
        flt_pkg::ADDR_LEVEL: begin
          st_nxt.rdata = enhanced ? {24'h000000, level_view}
                                  : flt_pkg::UNMAPPED_DATA;
        end
        flt_pkg::ADDR_FEATURE: begin
          st_nxt.rdata = enhanced ? {24'h000000, st_r.feature_control}
                                  : flt_pkg::UNMAPPED_DATA;
        end
        flt_pkg::ADDR_LINE_CTRL: begin
          st_nxt.rdata = {24'h000000, st_r.line_control};
        end
        flt_pkg::ADDR_RX_COUNT: begin
          st_nxt.rdata = {25'h0000000, rx_count};
        end
        flt_pkg::ADDR_TX_COUNT: begin
          st_nxt.rdata = {25'h0000000, tx_count};
        end
        flt_pkg::ADDR_TRIG_STAT: begin
          st_nxt.rdata = {17'h00000, st_r.tx_trig, 1'b0, st_r.rx_trig};
        end
        default: begin
          st_nxt.rdata = flt_pkg::UNMAPPED_DATA;
        end
      endcase
    end
    // toggle once per completed level read, not per wait cycle
    if (rd_accept && enhanced && address == flt_pkg::ADDR_LEVEL) begin
      st_nxt.sel_tx = ~st_r.sel_tx;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r.line_control <= flt_pkg::LINE_CTRL_RST;
      st_r.feature_control <= flt_pkg::FEATURE_RST;
      st_r.rx_trig <= flt_pkg::TRIG_RST;
      st_r.tx_trig <= flt_pkg::TRIG_RST;
      st_r.sel_tx <= flt_pkg::LEVEL_RST[7];
      st_r.rdata <= flt_pkg::UNMAPPED_DATA;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign readdata = st_r.rdata;
  assign receive_trigger_level = st_r.rx_trig;
  assign transmit_trigger_level = st_r.tx_trig;
  assign trigger_table =
    st_r.feature_control[flt_pkg::TABLE_MSB:flt_pkg::TABLE_LSB];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_RX_LOAD: assert property (
    (write && lane0 && enhanced && address == flt_pkg::ADDR_LEVEL &&
     !writedata[7]) |=> receive_trigger_level == $past(writedata[6:0]))
    else $error("rx trigger not loaded");
  AST_TX_LOAD: assert property (
    (write && lane0 && enhanced && address == flt_pkg::ADDR_LEVEL &&
     writedata[7]) |=> transmit_trigger_level == $past(writedata[6:0]))
    else $error("tx trigger not loaded");
  AST_TX_KEEP: assert property (
    (write && enhanced && address == flt_pkg::ADDR_LEVEL &&
     !writedata[7]) |=> $stable(transmit_trigger_level))
    else $error("tx trigger changed on rx write");
  AST_LOCKED: assert property (
    (write && !enhanced && address == flt_pkg::ADDR_LEVEL) |=>
      $stable(receive_trigger_level) && $stable(transmit_trigger_level))
    else $error("trigger written while locked");
  AST_LEVEL_RD: assert property (
    (read && !rd_accept && enhanced && address == flt_pkg::ADDR_LEVEL &&
     !st_r.sel_tx) ##1 rd_accept |-> readdata[7:0] == {1'b0,
     $past(rx_count)})
    else $error("rx level read wrong");
  AST_HIDDEN: assert property (
    (read && !rd_accept && !enhanced) ##1 rd_accept |->
      (address > flt_pkg::ADDR_FEATURE || readdata == 32'h0))
    else $error("enhanced register visible");
  AST_TOGGLE: assert property (
    (rd_accept && enhanced && address == flt_pkg::ADDR_LEVEL) |=>
      st_r.sel_tx != $past(st_r.sel_tx))
    else $error("selector did not toggle");
  property feature_control_reserved_stable;
    ##1 st_r.feature_control[7:6] == 2'b00;
  endproperty

  AST_RESERVED: assert property (
    feature_control_reserved_stable)
    else $error("reserved bits changed");
  AST_WAIT: assert property (
    (read && !rd_accept) |=> (!read || !waitrequest))
    else $error("read wait exceeds one cycle");

  COV_RX_THEN_TX: cover property (
    (rd_accept && enhanced && address == 10'h000 && !st_r.sel_tx) ##[1:20]
    (rd_accept && enhanced && address == 10'h000 && st_r.sel_tx));
  COV_TX_WRITE: cover property (
    write && enhanced && address == 10'h000 && writedata[7]);
  COV_TABLE_D: cover property (trigger_table == 2'b11);
endmodule

/* sim/tb_fifo_level_trigger_regs.sv */
// testbench: fifo trigger and level count registers over avalon
`timescale 1ns/1ns
module tb_fifo_level_trigger_regs;
  // ----------------------------------------------------------------
  // clock, reset and ports
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] address = 10'h000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] readdata;
  logic waitrequest;
  logic [6:0] rx_count = 7'h00;
  logic [6:0] tx_count = 7'h03;
  logic [6:0] rx_trig;
  logic [6:0] tx_trig;
  logic [1:0] trig_tab;
  logic [31:0] rd;
  int miscompares = 0;
  int n_checks = 0;

  always #2 ref_clk = ~ref_clk;

  flt_regs DUT (.ref_clk(ref_clk), .rst(rst), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .rx_count(rx_count),
    .tx_count(tx_count), .receive_trigger_level(rx_trig),
    .transmit_trigger_level(tx_trig), .trigger_table(trig_tab));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one avalon access; waitrequest and readdata are taken at the rising
  // edge itself, before that edge's register updates land
  task automatic bus(input logic wr, input logic [9:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    logic w;
    int nw;
    nw = 0;
    address <= a;
    writedata <= d;
    byteenable <= be;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge ref_clk);
      w = waitrequest;
      rd = readdata;
      if (w) begin
        nw++;
      end
    end while (w);
    read <= 1'b0;
    write <= 1'b0;
    // reads stall exactly one cycle, writes none
    chk(32'(nw), wr ? 32'h0 : 32'h1);
    // idle edge so no strobe is assigned twice in one time step
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d}, 4'h1);
  endtask

  task automatic rdchk(input logic [9:0] a, input logic [7:0] exp);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(rd, {24'h0, exp});
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk(rx_trig, 32'h0);
    chk(tx_trig, 32'h0);
    chk(trig_tab, 32'h2);
    wr(flt_pkg::ADDR_LINE_CTRL, flt_pkg::ENHANCED_KEY);
    rdchk(flt_pkg::ADDR_FEATURE, 8'h20);
    rdchk(flt_pkg::ADDR_LEVEL, 8'h00);
  endtask

  // selector now points at tx; counts differ so a wrong pick shows
  task automatic t_levels;
    rx_count <= 7'h40;
    tx_count <= 7'h05;
    rdchk(flt_pkg::ADDR_LEVEL, 8'h85);
    rdchk(flt_pkg::ADDR_LEVEL, 8'h40);
    rx_count <= 7'h00;
    tx_count <= 7'h40;
    rdchk(flt_pkg::ADDR_LEVEL, 8'hc0);
    rdchk(flt_pkg::ADDR_LEVEL, 8'h00);
  endtask

  // tx boundary levels 0 and 64, rx levels 5 and 0, other side must hold
  task automatic t_trig;
    logic [7:0] d[4] = '{8'h05, 8'hc0, 8'h00, 8'h80};
    logic [6:0] er[4] = '{7'h05, 7'h05, 7'h00, 7'h00};
    logic [6:0] et[4] = '{7'h00, 7'h40, 7'h40, 7'h00};
    for (int i = 0; i < 4; i++) begin
      wr(flt_pkg::ADDR_LEVEL, d[i]);
      chk(rx_trig, {25'h0, er[i]});
      chk(tx_trig, {25'h0, et[i]});
    end
  endtask

  // every table, with reserved bits written high
  task automatic t_feature;
    for (int i = 0; i < 4; i++) begin
      wr(flt_pkg::ADDR_FEATURE, 8'hc0 | 8'(i << 4));
      chk(trig_tab, 32'(i));
      rdchk(flt_pkg::ADDR_FEATURE, 8'(i << 4));
    end
  endtask

  // locked access, unmapped read, write without byte lane 0
  task automatic t_lock;
    wr(flt_pkg::ADDR_LINE_CTRL, 8'h00);
    wr(flt_pkg::ADDR_LEVEL, 8'h0a);
    chk(rx_trig, 32'h0);
    wr(flt_pkg::ADDR_FEATURE, 8'h10);
    rdchk(flt_pkg::ADDR_FEATURE, 8'h00);
    rdchk(flt_pkg::ADDR_LEVEL, 8'h00);
    rdchk(10'h3fc, 8'h00);
    wr(flt_pkg::ADDR_LINE_CTRL, flt_pkg::ENHANCED_KEY);
    bus(1'b1, flt_pkg::ADDR_FEATURE, 32'h0, 4'h0);
    chk(trig_tab, 32'h3);
    rdchk(flt_pkg::ADDR_FEATURE, 8'h30);
    rdchk(flt_pkg::ADDR_LEVEL, 8'hc0);
  endtask

  // ----------------------------------------------------------------
  // verdict, watchdog and main sequence
  // ----------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // about 30 accesses of a few cycles each fit well inside this span
  initial begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    end_of_test();
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_levels();
    t_trig();
    t_feature();
    t_lock();
    end_of_test();
  end
endmodule
